// ===== src/vrc_config_regs.v
// Functional notes
// [R01] current limit sampled at power up, read-only
// [R02] max temperature resets 64h, writable, sets alarm
// [R03] fast slew register reads 0Ah, read-only
// [R04] slow commands ramp quarter rate; reads 02h
// [R05] ramp to boot voltage, hold until command or output code write
// [R06] code above maximum gets not-supported answer
// [R07] master programs the maximum output code
// [R08] output code register read-write, resets zero
// [R09] power state register read-write, resets zero
// [R10] signed margin steps added to output code
// [R11] boot strap measured and decoded at power up
// [R12] boot register never changes after power up
// [R13] eight boot levels with light-load phase count
// [R14] nine addresses from phase-one strap, latched
// [R15] address levels ascend from zero to eight
// [R16] temperature is plain binary degrees celsius
// [R17] alarm when temperature at or above maximum
`timescale 1ns/1ps
`include "vrc_defines.vh"

module vrc_config_regs #(
  parameter STEP_CW = 12
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_ack_out,
  output reg reg_err_out,
  input wire cmd_valid_in,
  input wire cmd_fast_in,
  input wire [7:0] cmd_code_in,
  output reg cmd_ack_out,
  output reg cmd_nack_out,
  input wire strap_valid_in,
  input wire [7:0] current_limit_strap_pin_in,
  input wire [7:0] boot_strap_pin_in,
  input wire [7:0] first_phase_address_strap_pin_in,
  input wire [7:0] temperature_in,
  output reg thermal_alarm_output_out,
  output reg [3:0] bus_address_out,
  output reg [1:0] light_load_phase_count_out,
  output reg strap_done_out,
  output wire [7:0] voltage_code_out,
  output wire at_target_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_n_reg;

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [32:0] pin_meta_reg;
  reg [32:0] pin_sync_reg;
  reg [32:0] pin_prev_reg;
  wire [32:0] pin_raw;

  assign pin_raw = {strap_valid_in, current_limit_strap_pin_in, boot_strap_pin_in,
    first_phase_address_strap_pin_in, temperature_in};

  always @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pin_meta_reg <= 33'h0;
      pin_sync_reg <= 33'h0;
      pin_prev_reg <= 33'h0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  wire strap_valid_s;
  wire [7:0] cur_limit_s;
  wire [7:0] boot_s;
  wire [7:0] addr_s;
  wire [7:0] temp_s;

  assign strap_valid_s = pin_sync_reg[32];
  assign cur_limit_s = pin_sync_reg[31:24];
  assign boot_s = pin_sync_reg[23:16];
  assign addr_s = pin_sync_reg[15:8];
  assign temp_s = pin_sync_reg[7:0];

  // a word is used only once two synced samples agree, so a
  // half-changed adc code is never acted on
  wire straps_settled;
  wire temp_settled;

  assign straps_settled = (pin_sync_reg[31:8] == pin_prev_reg[31:8]);
  assign temp_settled = (pin_sync_reg[7:0] == pin_prev_reg[7:0]);

  // ----------------------------------------------------------------
  // strap decoders
  // ----------------------------------------------------------------
  wire [3:0] boot_level;
  wire [3:0] addr_level;

  vrc_strap_decoder #(
    .W(8),
    .LEVELS(8),
    .LW(4),
    .THRESH(`VRC_BOOT_THRESH)
  ) u_boot_dec (
    .sample_in(boot_s),
    .level_out(boot_level)
  ); // R11

  vrc_strap_decoder #(
    .W(8),
    .LEVELS(9),
    .LW(4),
    .THRESH(`VRC_ADDR_THRESH)
  ) u_addr_dec (
    .sample_in(addr_s),
    .level_out(addr_level)
  ); // R14

  reg [7:0] boot_code;

  always @*
  begin
    case (boot_level[1:0]) // R13
      2'h0: boot_code = `VRC_VBOOT_0V00;
      2'h1: boot_code = `VRC_VBOOT_1V65;
      2'h2: boot_code = `VRC_VBOOT_1V70;
      default: boot_code = `VRC_VBOOT_1V75;
    endcase
  end

  // ----------------------------------------------------------------
  // strap capture, once per power up
  // ----------------------------------------------------------------
  reg [7:0] cur_limit_reg;
  reg [7:0] boot_v_reg;

  always @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      strap_done_out <= 1'b0;
      cur_limit_reg <= `VRC_RST_CUR_LIMIT;
      boot_v_reg <= `VRC_RST_BOOT_V;
      bus_address_out <= 4'h0;
      light_load_phase_count_out <= 2'h1;
    end
    else if (strap_valid_s && straps_settled && !strap_done_out) // R12
    begin
      strap_done_out <= 1'b1;
      cur_limit_reg <= cur_limit_s; // R01
      boot_v_reg <= boot_code; // R11
      bus_address_out <= addr_level; // R15
      light_load_phase_count_out <= boot_level[2] ? 2'h2 : 2'h1; // R13
    end
  end

  // ----------------------------------------------------------------
  // thermal alarm
  // ----------------------------------------------------------------
  reg [7:0] max_temp_reg;
  reg [7:0] temp_hold_reg;

  always @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      temp_hold_reg <= 8'h00;
    else if (temp_settled)
      temp_hold_reg <= temp_s; // R16
  end

  always @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      thermal_alarm_output_out <= 1'b0;
    else
      thermal_alarm_output_out <= (temp_hold_reg >= max_temp_reg); // R16 R17
  end

  // ----------------------------------------------------------------
  // register bank and voltage-set commands
  // ----------------------------------------------------------------
  reg [7:0] max_out_reg;
  reg [7:0] out_code_reg;
  reg [7:0] pwr_state_reg;
  reg [7:0] margin_reg;
  reg boot_hold_reg;
  reg rate_fast_reg;
  reg addr_hit;
  reg addr_ro;
  reg [7:0] rd_mux;
  wire cmd_ok;

  assign cmd_ok = (cmd_code_in <= max_out_reg); // R06 R07

  always @*
  begin
    addr_hit = 1'b1;
    addr_ro = 1'b0;
    rd_mux = 8'h00;
    case (reg_addr_in)
      `VRC_OFS_CUR_LIMIT:
      begin
        rd_mux = cur_limit_reg;
        addr_ro = 1'b1; // R01
      end
      `VRC_OFS_MAX_TEMP: rd_mux = max_temp_reg;
      `VRC_OFS_FAST_SR:
      begin
        rd_mux = `VRC_FAST_SR_MV_PER_US; // R03
        addr_ro = 1'b1;
      end
      `VRC_OFS_SLOW_SR:
      begin
        rd_mux = `VRC_SLOW_SR_MV_PER_US; // R04
        addr_ro = 1'b1;
      end
      `VRC_OFS_BOOT_V:
      begin
        rd_mux = boot_v_reg;
        addr_ro = 1'b1; // R12
      end
      `VRC_OFS_MAX_OUT: rd_mux = max_out_reg;
      `VRC_OFS_OUT_CODE: rd_mux = out_code_reg; // R08
      `VRC_OFS_PWR_STATE: rd_mux = pwr_state_reg; // R09
      `VRC_OFS_MARGIN: rd_mux = margin_reg;
      default: addr_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      max_temp_reg <= `VRC_RST_MAX_TEMP; // R02
      max_out_reg <= `VRC_RST_MAX_OUT; // R06
      out_code_reg <= `VRC_RST_OUT_CODE; // R08
      pwr_state_reg <= `VRC_RST_PWR_STATE; // R09
      margin_reg <= `VRC_RST_MARGIN;
      boot_hold_reg <= 1'b1;
      rate_fast_reg <= 1'b1;
      reg_rdata_out <= 8'h00;
      reg_ack_out <= 1'b0;
      reg_err_out <= 1'b0;
      cmd_ack_out <= 1'b0;
      cmd_nack_out <= 1'b0;
    end
    else
    begin
      reg_ack_out <= reg_rd_in || reg_wr_in;
      reg_err_out <= (reg_rd_in && !addr_hit) || (reg_wr_in && (!addr_hit || addr_ro));
      if (reg_rd_in)
        reg_rdata_out <= rd_mux;
      if (reg_wr_in && addr_hit && !addr_ro)
      begin
        case (reg_addr_in)
          `VRC_OFS_MAX_TEMP: max_temp_reg <= reg_wdata_in; // R02
          `VRC_OFS_MAX_OUT: max_out_reg <= reg_wdata_in; // R07
          `VRC_OFS_OUT_CODE:
          begin
            out_code_reg <= reg_wdata_in; // R08
            boot_hold_reg <= 1'b0;
            rate_fast_reg <= 1'b1;
          end
          `VRC_OFS_PWR_STATE: pwr_state_reg <= reg_wdata_in; // R09
          `VRC_OFS_MARGIN: margin_reg <= reg_wdata_in; // R10
          default: max_temp_reg <= max_temp_reg;
        endcase
      end
      // an accepted command overrides a same-cycle register write of the code
      cmd_ack_out <= cmd_valid_in && cmd_ok;
      cmd_nack_out <= cmd_valid_in && !cmd_ok; // R06
      if (cmd_valid_in && cmd_ok)
      begin
        out_code_reg <= cmd_code_in;
        boot_hold_reg <= 1'b0; // R05
        rate_fast_reg <= cmd_fast_in; // R04
      end
    end
  end

  // ----------------------------------------------------------------
  // target code with margin, clamped to code range
  // ----------------------------------------------------------------
  wire [9:0] margin_sum;
  reg [7:0] target;

  assign margin_sum = {2'b00, out_code_reg} + {{2{margin_reg[7]}}, margin_reg}; // R10

  always @*
  begin
    if (!strap_done_out)
      target = 8'h00;
    else if (boot_hold_reg)
      target = boot_v_reg; // R05
    else if (margin_sum[9])
      target = 8'h00;
    else if (margin_sum[8])
      target = 8'hFF;
    else
      target = margin_sum[7:0];
  end

  // ----------------------------------------------------------------
  // output ramp
  // ----------------------------------------------------------------
  localparam integer FAST_STEP_I = `VRC_FAST_STEP_CYCLES;
  localparam integer SLOW_STEP_I = `VRC_SLOW_STEP_CYCLES;
  localparam [STEP_CW-1:0] FAST_STEP = FAST_STEP_I[STEP_CW-1:0];
  localparam [STEP_CW-1:0] SLOW_STEP = SLOW_STEP_I[STEP_CW-1:0];

  vrc_slew_ramp #(
    .W(8),
    .CW(STEP_CW)
  ) u_ramp (
    .clk_in(clk_in),
    .rst_n_in(rst_n_reg),
    .target_in(target),
    .step_cycles_in(rate_fast_reg ? FAST_STEP : SLOW_STEP), // R03 R04
    .code_out(voltage_code_out),
    .at_target_out(at_target_out)
  ); // R05

endmodule // vrc_config_regs

// ===== src/vrc_defines.vh
`ifndef VRC_DEFINES_VH
`define VRC_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VRC_OFS_CUR_LIMIT 8'h21
`define VRC_OFS_MAX_TEMP 8'h22
`define VRC_OFS_FAST_SR 8'h24
`define VRC_OFS_SLOW_SR 8'h25
`define VRC_OFS_BOOT_V 8'h26
`define VRC_OFS_MAX_OUT 8'h30
`define VRC_OFS_OUT_CODE 8'h31
`define VRC_OFS_PWR_STATE 8'h32
`define VRC_OFS_MARGIN 8'h33

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VRC_RST_CUR_LIMIT 8'h00
`define VRC_RST_MAX_TEMP 8'h64
`define VRC_RST_BOOT_V 8'h00
`define VRC_RST_MAX_OUT 8'hB5
`define VRC_RST_OUT_CODE 8'h00
`define VRC_RST_PWR_STATE 8'h00
`define VRC_RST_MARGIN 8'h00

// ----------------------------------------------------------------
// slew rates and timing
// ----------------------------------------------------------------
`define VRC_FAST_SR_MV_PER_US 8'h0A
`define VRC_SLOW_DIVISOR 4
`define VRC_SLOW_SR_MV_PER_US 8'h02
`define VRC_CLK_MHZ 100
`define VRC_VID_STEP_MV 5
`define VRC_FAST_STEP_CYCLES ((`VRC_VID_STEP_MV * `VRC_CLK_MHZ) / 10)
`define VRC_SLOW_STEP_CYCLES (`VRC_FAST_STEP_CYCLES * `VRC_SLOW_DIVISOR)

// ----------------------------------------------------------------
// boot voltage codes per strap level
// ----------------------------------------------------------------
`define VRC_VBOOT_0V00 8'h00
`define VRC_VBOOT_1V65 8'hA6
`define VRC_VBOOT_1V70 8'hAB
`define VRC_VBOOT_1V75 8'hB0

// ----------------------------------------------------------------
// strap thresholds in adc counts, highest level first
// ----------------------------------------------------------------
`define VRC_BOOT_THRESH {8'hEC, 8'hCC, 8'hB3, 8'h8D, 8'h67, 8'h4D, 8'h33}
`define VRC_ADDR_THRESH {8'hF0, 8'hB4, 8'h87, 8'h66, 8'h4C, 8'h38, 8'h25, 8'h14}

`endif

// ===== src/vrc_strap_decoder.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// level decoder: counts thresholds at or below the sample
// ----------------------------------------------------------------
module vrc_strap_decoder #(
  parameter W = 8,
  parameter LEVELS = 8,
  parameter LW = 4,
  parameter [W*(LEVELS-1)-1:0] THRESH = {(W*(LEVELS-1)){1'b0}}
) (
  input wire [W-1:0] sample_in,
  output reg [LW-1:0] level_out
);

  integer i;

  always @*
  begin
    level_out = {LW{1'b0}};
    for (i = 0; i < LEVELS - 1; i = i + 1)
    begin
      if (sample_in >= THRESH[i*W +: W])
      begin
        level_out = level_out + {{(LW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // vrc_strap_decoder

// ===== src/vrc_slew_ramp.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// output code ramp: one code step per step_cycles_in clocks
// ----------------------------------------------------------------
module vrc_slew_ramp #(
  parameter W = 8,
  parameter CW = 12
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [W-1:0] target_in,
  input wire [CW-1:0] step_cycles_in,
  output reg [W-1:0] code_out,
  output reg at_target_out
);

  reg [CW-1:0] cnt_reg;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= {CW{1'b0}};
      code_out <= {W{1'b0}};
      at_target_out <= 1'b1;
    end
    else if (code_out == target_in)
    begin
      cnt_reg <= {CW{1'b0}};
      at_target_out <= 1'b1;
    end
    else
    begin
      at_target_out <= 1'b0;
      if (cnt_reg >= step_cycles_in - {{(CW-1){1'b0}}, 1'b1})
      begin
        cnt_reg <= {CW{1'b0}};
        if (code_out < target_in)
          code_out <= code_out + {{(W-1){1'b0}}, 1'b1};
        else
          code_out <= code_out - {{(W-1){1'b0}}, 1'b1};
      end
      else
      begin
        cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // vrc_slew_ramp

// ===== testbench/vrc_config_regs_assertions.sv
`timescale 1ns/1ps
module vrc_config_regs_checker (
  input wire clk_in,
  input wire nrst_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire reg_ack_out,
  input wire cmd_valid_in,
  input wire cmd_ack_out,
  input wire cmd_nack_out,
  input wire reg_err_out,
  input wire [3:0] bus_address_out,
  input wire [1:0] light_load_phase_count_out,
  input wire strap_done_out,
  input wire [7:0] voltage_code_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rd(a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence s_done2;
    strap_done_out ##1 strap_done_out;
  endsequence
  property p_ack;
    reg_rd_in || reg_wr_in |=> reg_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("register access not answered");
  property p_ro;
    reg_wr_in && (reg_addr_in == 8'h21 || reg_addr_in == 8'h24 || reg_addr_in == 8'h25
      || reg_addr_in == 8'h26) |=> reg_err_out;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write not refused");
  property p_fast;
    s_rd(8'h24) |=> reg_rdata_out == 8'h0A;
  endproperty
  a_fast: assert property (p_fast) else $error("fast slew value wrong");
  property p_slow;
    s_rd(8'h25) |=> reg_rdata_out == 8'h02;
  endproperty
  a_slow: assert property (p_slow) else $error("slow slew value wrong");
  property p_cmd;
    cmd_valid_in |=> cmd_ack_out != cmd_nack_out;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command answer wrong");
  property p_keep;
    strap_done_out |=> strap_done_out;
  endproperty
  a_keep: assert property (p_keep) else $error("strap capture undone");
  property p_latch;
    s_done2 |-> $stable(bus_address_out) && $stable(light_load_phase_count_out);
  endproperty
  a_latch: assert property (p_latch) else $error("latched strap changed");
  property p_addr;
    strap_done_out |-> bus_address_out <= 4'h8;
  endproperty
  a_addr: assert property (p_addr) else $error("address out of range");
  property p_phase;
    strap_done_out |-> light_load_phase_count_out == 2'h1 || light_load_phase_count_out == 2'h2;
  endproperty
  a_phase: assert property (p_phase) else $error("phase count invalid");
  property p_step;
    $changed(voltage_code_out) |=> $stable(voltage_code_out) [*8];
  endproperty
  a_step: assert property (p_step) else $error("ramp stepped too fast");
endmodule // vrc_config_regs_checker

bind vrc_config_regs vrc_config_regs_checker u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .reg_err_out(reg_err_out),
  .cmd_valid_in(cmd_valid_in), .cmd_ack_out(cmd_ack_out), .cmd_nack_out(cmd_nack_out),
  .bus_address_out(bus_address_out), .strap_done_out(strap_done_out),
  .light_load_phase_count_out(light_load_phase_count_out), .voltage_code_out(voltage_code_out));

// ===== testbench/vrc_bus_master.sv
`timescale 1ns/1ps
module vrc_bus_master (
  input wire clk_in,
  output reg [7:0] addr_out,
  output reg [7:0] wdata_out,
  output reg wr_out,
  output reg rd_out,
  output reg cmd_valid_out,
  output reg cmd_fast_out,
  output reg [7:0] cmd_code_out
);
  initial
  begin
    {addr_out, wdata_out, wr_out, rd_out, cmd_valid_out, cmd_fast_out, cmd_code_out} = 28'h0;
  end
  // one-cycle strobe, fields held with it
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
      @(posedge clk_in);
      wr_out <= w;
      rd_out <= !w;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
    end
  endtask
  // voltage-set command; the maximum code is ours to program
  task cmd(input logic f, input logic [7:0] c);
    begin
      @(posedge clk_in);
      cmd_valid_out <= 1'b1;
      cmd_fast_out <= f;
      cmd_code_out <= c;
      @(posedge clk_in);
      cmd_valid_out <= 1'b0;
    end
  endtask
endmodule // vrc_bus_master

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [7:0] cl = 8'h00;
  reg [7:0] bt = 8'hB8;
  reg [7:0] ad = 8'h70;
  reg [7:0] tp = 8'h10;
  reg sv = 1'b0;
  wire [7:0] a, wd, cc, rdat, vc;
  wire wr, rd, cv, cf, ack, err, cack, cnack, alarm, done, att;
  wire [3:0] ba;
  wire [1:0] ph;
  integer mismatches = 0, comparisons = 0, cycles = 0, seed = 40, i, n;
  logic [9:0] eq[$];
  logic [1:0] cq[$];
  logic [9:0] e;
  logic [7:0] cl0, t;
  logic [7:0] ta[10] = '{8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h30, 8'h31, 8'h32, 8'h33, 8'h23};
  logic [7:0] tv[10] = '{8'h00, 8'h64, 8'h0A, 8'h02, 8'hA6, 8'hB5, 8'h00, 8'h00, 8'h00, 8'h00};

  always #5 clk_in = ~clk_in;

  vrc_bus_master u_m (.clk_in(clk_in), .addr_out(a), .wdata_out(wd), .wr_out(wr), .rd_out(rd),
    .cmd_valid_out(cv), .cmd_fast_out(cf), .cmd_code_out(cc));
  vrc_config_regs u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(a),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .reg_ack_out(ack), .reg_err_out(err), .cmd_valid_in(cv), .cmd_fast_in(cf),
    .cmd_code_in(cc), .cmd_ack_out(cack), .cmd_nack_out(cnack), .strap_valid_in(sv),
    .current_limit_strap_pin_in(cl), .boot_strap_pin_in(bt),
    .first_phase_address_strap_pin_in(ad), .temperature_in(tp),
    .thermal_alarm_output_out(alarm), .bus_address_out(ba), .light_load_phase_count_out(ph),
    .strap_done_out(done), .voltage_code_out(vc), .at_target_out(att));

  task check(input string nm, input logic [7:0] s, input logic [7:0] x);
    begin
      comparisons++;
      if (s !== x)
      begin
        mismatches++;
        $display("BAD %s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task rdx(input logic [7:0] ra, input logic [7:0] x, input logic er);
    begin
      eq.push_back({1'b1, er, x});
      u_m.acc(1'b0, ra, 8'h00);
    end
  endtask
  task wrx(input logic [7:0] ra, input logic [7:0] d, input logic er);
    begin
      eq.push_back({1'b0, er, 8'h00});
      u_m.acc(1'b1, ra, d);
    end
  endtask
  task cmdx(input logic f, input logic [7:0] c, input logic nk);
    begin
      cq.push_back({!nk, nk});
      u_m.cmd(f, c);
    end
  endtask
  task wait_code(input logic [7:0] x);
    begin
      n = 0;
      while (vc !== x && n < 12000)
      begin
        @(posedge clk_in);
        n++;
      end
      check("code", vc, x);
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always @(negedge clk_in)
  begin
    if (ack === 1'b1)
    begin
      e = (eq.size() > 0) ? eq.pop_front() : 10'h3FF;
      check("err", {7'h0, err}, {7'h0, e[8]});
      if (e[9])
        check("rdata", rdat, e[7:0]);
    end
    if (cack === 1'b1 || cnack === 1'b1)
    begin
      e = (cq.size() > 0) ? {8'h0, cq.pop_front()} : 10'h0;
      check("cmd", {6'h0, cack, cnack}, e[7:0]);
    end
  end
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n = $random(seed);
    cl0 = n[7:0];
    cl = cl0;
    tv[0] = cl0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    check("done", {7'h0, done}, 8'h00);
    sv <= 1'b1;
    repeat (8) @(posedge clk_in);
    check("done", {7'h0, done}, 8'h01);
    check("at target", {7'h0, att}, 8'h00);
    check("addr", {4'h0, ba}, 8'h05);
    check("phase", {6'h0, ph}, 8'h02);
    cl <= ~cl0;
    bt <= 8'h10;
    ad <= 8'h10;
    @(vc);
    n = cycles;
    @(vc);
    n = cycles - n;
    check("fast step", n[7:0], 8'h32);
    wait_code(8'hA6);
    repeat (100) @(posedge clk_in);
    check("hold", vc, 8'hA6);
    check("at target", {7'h0, att}, 8'h01);
    $display("test straps and boot done");
    for (i = 0; i < 10; i++)
      rdx(ta[i], tv[i], i == 9);
    for (i = 0; i < 5; i++)
      if (i != 1)
      begin
        wrx(ta[i], 8'h5A, 1'b1);
        rdx(ta[i], tv[i], 1'b0);
      end
    for (i = 5; i < 9; i++)
    begin
      n = $random(seed);
      t = n[7:0];
      wrx(ta[i], t, 1'b0);
      rdx(ta[i], t, 1'b0);
    end
    $display("test registers done");
    wrx(8'h30, 8'hA8, 1'b0);
    wrx(8'h33, 8'h00, 1'b0);
    for (i = 0; i < 6; i++)
    begin
      n = $random(seed);
      t = n[7:0];
      cmdx(t[0], t, t > 8'hA8);
    end
    cmdx(1'b1, 8'hA9, 1'b1);
    cmdx(1'b1, 8'hA8, 1'b0);
    cmdx(1'b0, 8'hFF, 1'b1);
    rdx(8'h31, 8'hA8, 1'b0);
    wrx(8'h33, 8'hFF, 1'b0);
    wait_code(8'hA7);
    $display("test commands done");
    cmdx(1'b0, 8'hA0, 1'b0);
    @(vc);
    n = cycles;
    @(vc);
    n = cycles - n;
    check("slow step", n[7:0], 8'hC8);
    wait_code(8'h9F);
    $display("test slow ramp done");
    n = $random(seed);
    t = n[7:0] | 8'h01;
    wrx(8'h22, t, 1'b0);
    tp <= t;
    repeat (8) @(posedge clk_in);
    check("alarm", {7'h0, alarm}, 8'h01);
    tp <= t - 8'h01;
    repeat (8) @(posedge clk_in);
    check("alarm", {7'h0, alarm}, 8'h00);
    $display("test alarm done");
    stop_test;
  end
endmodule // testbench
